//--- hw/cpuamd_pkg.sv
// Constants, types and decode helpers of the CPU address map decoder
package cpuamd_pkg;

  localparam int PHYS_W = 26;

  // Map boundaries
  localparam logic [31:0] ROM_END_64K  = 32'h0000FFFF;
  localparam logic [31:0] ROM_END_128K = 32'h0001FFFF;
  localparam logic [31:0] ROM_END_256K = 32'h0003FFFF;
  localparam logic [31:0] ROM_AREA_END = 32'h000FFFFF;
  localparam logic [31:0] RAM_PROH_LO  = 32'h03FF0000;
  localparam logic [31:0] RAM_BASE     = 32'h03FFC000;
  localparam logic [31:0] RAM_END      = 32'h03FFEFFF;
  localparam logic [31:0] PER_BASE     = 32'h03FFF000;
  localparam logic [31:0] PER_END      = 32'h03FFFFFF;
  localparam logic [25:0] RESET_ENTRY  = 26'h0000000;
  localparam logic [25:0] FETCH_STEP   = 26'h0000004;

  // Register byte offsets
  localparam logic [3:0] OFS_CALL_TABLE = 4'h0;
  localparam logic [3:0] OFS_CONTROL    = 4'h4;
  localparam logic [3:0] OFS_STATUS     = 4'h8;

  // Field positions
  localparam int CTL_ROM_LSB   = 0;
  localparam int STS_MODE_LSB  = 0;
  localparam int STS_LATCHED   = 2;
  localparam int STS_FAULT     = 8;
  localparam int CT_PTR_MSB    = 25;

  // Reset values
  localparam logic [25:1] CALL_TABLE_RST = 25'h0000000;
  localparam logic [1:0]  ROM_SEL_RST    = 2'h2;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_FLASH_PROG,
    MODE_PROHIBITED
  } cpuamd_mode_e;

  typedef enum logic [1:0] {
    SIZE_BYTE,
    SIZE_HALF,
    SIZE_WORD
  } cpuamd_size_e;

  typedef enum logic [1:0] {
    REG_ROM,
    REG_RAM,
    REG_PER,
    REG_PROH
  } cpuamd_region_e;

  // Region of a 26-bit physical address for a given ROM size select
  function automatic cpuamd_region_e cpuamdDecode(
    input logic [25:0] phys,
    input logic [1:0]  romSel
  );
    logic [31:0] a;
    logic [31:0] romEnd;
    a = {6'h00, phys};
    romEnd = (romSel == 2'h0) ? ROM_END_64K :
             (romSel == 2'h1) ? ROM_END_128K : ROM_END_256K;
    if (a <= romEnd)
      return REG_ROM;
    else if (a >= RAM_BASE && a <= RAM_END)
      return REG_RAM;
    else if (a >= PER_BASE && a <= PER_END)
      return REG_PER;
    else
      return REG_PROH;
  endfunction

endpackage

//--- hw/cpuamd_per_if.sv
// Request carrier between the decoder and the peripheral splitter
interface cpuamd_per_if;
  import cpuamd_pkg::*;
  logic         req;
  logic         we;
  cpuamd_size_e size;
  logic [11:0]  addr;
  logic [31:0]  wdata;
  logic         done;
  logic [31:0]  rdata;
  modport master (output req, we, size, addr, wdata, input done, rdata);
  modport slave  (input req, we, size, addr, wdata, output done, rdata);
endinterface

//--- hw/cpuamd_per_split.sv
// Splits peripheral accesses into halfword bus cycles
module cpuamd_per_split
  import cpuamd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstN,
  input  wire logic        clkEn,
  cpuamd_per_if.slave      up,
  output logic             perReq_r,
  output logic             perWe_r,
  output logic [11:0]      perAddr_r,
  output logic [1:0]       perBe_r,
  output logic [15:0]      perWdata_r,
  input  wire logic        perAck,
  input  wire logic        perByteReg,
  input  wire logic [15:0] perRdata
);
  typedef enum logic [1:0] {SP_IDLE, SP_LOW, SP_HIGH} cpuamd_sp_e;
  cpuamd_sp_e  state_r;
  logic [15:0] lowHalf_r;
  logic [15:0] hiWdata_r;
  logic        wordOp_r;
  logic        done_r;
  logic [31:0] rdata_r;
  logic        fetchDone;

  assign up.done  = done_r;
  assign up.rdata = rdata_r;
  assign fetchDone = perReq_r && perAck;

  always_ff @(posedge clk or negedge rstN)
    if (!rstN)
    begin
      state_r <= SP_IDLE;
      perReq_r <= 1'b0;
      perWe_r <= 1'b0;
      perAddr_r <= 12'h000;
      perBe_r <= 2'h0;
      perWdata_r <= 16'h0000;
      hiWdata_r <= 16'h0000;
      lowHalf_r <= 16'h0000;
      wordOp_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end
    else if (clkEn)
    begin
      done_r <= 1'b0;
      unique case (state_r)
        SP_IDLE:
          if (up.req)
          begin
            perReq_r <= 1'b1;
            perWe_r <= up.we;
            hiWdata_r <= up.wdata[31:16];
            wordOp_r <= up.size == SIZE_WORD;
            if (up.size == SIZE_WORD)
            begin
              perAddr_r <= {up.addr[11:2], 2'b00};
              perBe_r <= 2'h3;
              perWdata_r <= up.wdata[15:0];
              state_r <= SP_LOW;
            end
            else if (up.size == SIZE_HALF)
            begin
              perAddr_r <= {up.addr[11:1], 1'b0};
              perBe_r <= 2'h3;
              perWdata_r <= up.wdata[15:0];
              state_r <= SP_HIGH;
            end
            else
            begin
              perAddr_r <= {up.addr[11:1], 1'b0};
              perBe_r <= up.addr[0] ? 2'h2 : 2'h1;
              perWdata_r <= {up.wdata[7:0], up.wdata[7:0]};
              state_r <= SP_HIGH;
            end
          end
        SP_LOW:
          if (fetchDone)
          begin
            lowHalf_r <= perRdata;
            perAddr_r <= {perAddr_r[11:2], 2'b10};
            perWdata_r <= hiWdata_r;
            perBe_r <= perByteReg ? 2'h1 : 2'h3;
            state_r <= SP_HIGH;
          end
          else if (perReq_r && perByteReg)
            perBe_r <= 2'h1;
        SP_HIGH:
          if (fetchDone)
          begin
            perReq_r <= 1'b0;
            done_r <= 1'b1;
            state_r <= SP_IDLE;
            // Halfword and byte reads zero-fill the upper half
            if (wordOp_r)
              rdata_r <= {perRdata, lowHalf_r};
            else
              rdata_r <= {16'h0000, perRdata};
          end
          else if (perReq_r && perByteReg && perBe_r == 2'h3)
            perBe_r <= 2'h1;
        default:
          state_r <= SP_IDLE;
      endcase
    end
endmodule // cpuamd_per_split

//--- hw/cpuamd_top.sv
// CPU address map decoder: mode select, wraparound and region routing
module cpuamd_top
  import cpuamd_pkg::*;
#(
  parameter logic [1:0] ROM_SEL_DEFAULT = ROM_SEL_RST
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clkEn,
  input  wire logic         flashModePinA,
  input  wire logic         flashModePinB,
  // Wishbone classic slave
  input  wire logic         wbCyc,
  input  wire logic         wbStb,
  input  wire logic         wbWe,
  input  wire logic [3:0]   wbAdr,
  input  wire logic [3:0]   wbSel,
  input  wire logic [31:0]  wbDatW,
  output logic [31:0]       wbDatR_r,
  output logic              wbAck_r,
  // Mode and boot
  output cpuamd_mode_e      mode_r,
  output logic              modeValid_r,
  output logic              bootStart_r,
  output logic [31:0]       callTablePtr_r,
  // Instruction fetch
  input  wire logic         fetchReq,
  input  wire logic [31:0]  fetchBase,
  input  wire logic [31:0]  fetchDisp,
  output logic              fetchAck_r,
  output logic [31:0]       fetchPc_r,
  output logic              fetchFault_r,
  output logic              prefetchOk_r,
  // Operand access
  input  wire logic         opReq,
  input  wire logic         opWe,
  input  wire cpuamd_size_e opSize,
  input  wire logic [31:0]  opBase,
  input  wire logic [31:0]  opDisp,
  input  wire logic [31:0]  opWdata,
  output logic              opAck_r,
  output logic              opFault_r,
  output logic [31:0]       opRdata_r,
  // ROM and RAM port
  output logic              memReq_r,
  output logic              memWe_r,
  output logic              memRam_r,
  output cpuamd_size_e      memSize_r,
  output logic [31:0]       memAddr_r,
  output logic [31:0]       memWdata_r,
  input  wire logic         memAck,
  input  wire logic [31:0]  memRdata,
  // Peripheral halfword port
  output logic              perReq_r,
  output logic              perWe_r,
  output logic [11:0]       perAddr_r,
  output logic [1:0]        perBe_r,
  output logic [15:0]       perWdata_r,
  input  wire logic         perAck,
  input  wire logic         perByteReg,
  input  wire logic [15:0]  perRdata
);
  typedef enum logic [1:0] {OP_IDLE, OP_MEM, OP_PER} cpuamd_op_e;

  logic           rstMeta_r;
  logic           rstN;
  logic [25:1]    callTable_r;
  logic [1:0]     romSel_r;
  logic           faultFlag_r;
  logic           wbHit;
  logic [31:0]    wbMask;
  logic           faultEvent;
  cpuamd_op_e     opState_r;
  logic [31:0]    opSum;
  logic [25:0]    opPhys;
  cpuamd_region_e opRegion;
  logic [31:0]    pcSum;
  logic [25:0]    pcPhys;
  logic [25:0]    pcNextWord;
  cpuamd_region_e pcRegion;
  logic           running;
  logic           perPend_r;

  cpuamd_per_if perBus ();

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      rstMeta_r <= 1'b0;
      rstN <= 1'b0;
    end
    else
    begin
      rstMeta_r <= 1'b1;
      rstN <= rstMeta_r;
    end

  // Mode capture at first enabled edge after release
  always_ff @(posedge clk or negedge rstN)
    if (!rstN)
    begin
      mode_r <= MODE_NORMAL;
      modeValid_r <= 1'b0;
      bootStart_r <= 1'b0;
    end
    else if (clkEn)
    begin
      bootStart_r <= 1'b0;
      if (!modeValid_r)
      begin
        modeValid_r <= 1'b1;
        if (!flashModePinA)
        begin
          mode_r <= MODE_NORMAL;
          bootStart_r <= 1'b1;
        end
        else if (!flashModePinB)
          mode_r <= MODE_FLASH_PROG;
        else
          mode_r <= MODE_PROHIBITED;
      end
    end

  assign running = modeValid_r && mode_r == MODE_NORMAL;

  // Wishbone register access
  assign wbHit = wbCyc && wbStb && !wbAck_r;
  assign wbMask = {{8{wbSel[3]}}, {8{wbSel[2]}}, {8{wbSel[1]}},
                   {8{wbSel[0]}}};

  always_ff @(posedge clk or negedge rstN)
    if (!rstN)
    begin
      wbAck_r <= 1'b0;
      wbDatR_r <= 32'h00000000;
    end
    else if (clkEn)
    begin
      wbAck_r <= wbHit;
      if (wbHit && !wbWe)
        unique case (wbAdr)
          OFS_CALL_TABLE:
            wbDatR_r <= {6'h00, callTable_r, 1'b0};
          OFS_CONTROL:
            wbDatR_r <= {30'h00000000, romSel_r};
          OFS_STATUS:
          begin
            wbDatR_r <= 32'h00000000;
            wbDatR_r[STS_MODE_LSB +: 2] <= mode_r;
            wbDatR_r[STS_LATCHED] <= modeValid_r;
            wbDatR_r[STS_FAULT] <= faultFlag_r;
          end
          default:
            wbDatR_r <= 32'h00000000;
        endcase
    end

  // Pointer keeps only bits 25..1
  always_ff @(posedge clk or negedge rstN)
    if (!rstN)
      callTable_r <= CALL_TABLE_RST;
    else if (clkEn && wbHit && wbWe && wbAdr == OFS_CALL_TABLE)
      callTable_r <= (callTable_r & ~wbMask[CT_PTR_MSB:1])
                   | (wbDatW[CT_PTR_MSB:1] & wbMask[CT_PTR_MSB:1]);

  always_ff @(posedge clk or negedge rstN)
    if (!rstN)
      callTablePtr_r <= 32'h00000000;
    else if (clkEn)
      callTablePtr_r <= {6'h00, callTable_r, 1'b0};

  always_ff @(posedge clk or negedge rstN)
    if (!rstN)
      romSel_r <= ROM_SEL_DEFAULT;
    else if (clkEn && wbHit && wbWe && wbAdr == OFS_CONTROL && wbSel[0]
             && wbDatW[CTL_ROM_LSB +: 2] != 2'h3)
      romSel_r <= wbDatW[CTL_ROM_LSB +: 2];

  // Sticky fault, write one clears, new fault wins
  always_ff @(posedge clk or negedge rstN)
    if (!rstN)
      faultFlag_r <= 1'b0;
    else if (clkEn)
    begin
      if (faultEvent)
        faultFlag_r <= 1'b1;
      else if (wbHit && wbWe && wbAdr == OFS_STATUS && wbSel[1]
               && wbDatW[STS_FAULT])
        faultFlag_r <= 1'b0;
    end

  // Fetch address: 26-bit wrap, region check
  assign pcSum = fetchBase + fetchDisp;
  assign pcPhys = pcSum[25:0];
  assign pcNextWord = pcPhys + FETCH_STEP;
  assign pcRegion = cpuamdDecode(pcPhys, romSel_r);

  always_ff @(posedge clk or negedge rstN)
    if (!rstN)
    begin
      fetchAck_r <= 1'b0;
      fetchPc_r <= 32'h00000000;
      fetchFault_r <= 1'b0;
      prefetchOk_r <= 1'b0;
    end
    else if (clkEn)
    begin
      fetchAck_r <= 1'b0;
      if (bootStart_r)
      begin
        fetchPc_r <= {6'h00, RESET_ENTRY};
        prefetchOk_r <= 1'b1;
      end
      else if (running && fetchReq && !fetchAck_r)
      begin
        fetchAck_r <= 1'b1;
        fetchPc_r <= {6'h00, pcPhys};
        // ROM and RAM execute, peripheral and holes fault
        fetchFault_r <= !(pcRegion == REG_ROM
                          || pcRegion == REG_RAM);
        prefetchOk_r <= pcRegion != REG_PER
          && cpuamdDecode(pcNextWord, romSel_r) != REG_PER;
      end
    end

  // Operand address: 32-bit wrap, 26-bit image
  assign opSum = opBase + opDisp;
  assign opPhys = opSum[25:0];
  assign opRegion = cpuamdDecode(opPhys, romSel_r);

  assign faultEvent = (fetchAck_r && fetchFault_r)
                    || (opAck_r && opFault_r);

  assign perBus.req = perPend_r;

  always_ff @(posedge clk or negedge rstN)
    if (!rstN)
    begin
      opState_r <= OP_IDLE;
      opAck_r <= 1'b0;
      opFault_r <= 1'b0;
      opRdata_r <= 32'h00000000;
      memReq_r <= 1'b0;
      memWe_r <= 1'b0;
      memRam_r <= 1'b0;
      memSize_r <= SIZE_BYTE;
      memAddr_r <= 32'h00000000;
      memWdata_r <= 32'h00000000;
      perPend_r <= 1'b0;
      perBus.we <= 1'b0;
      perBus.size <= SIZE_BYTE;
      perBus.addr <= 12'h000;
      perBus.wdata <= 32'h00000000;
    end
    else if (clkEn)
    begin
      opAck_r <= 1'b0;
      perPend_r <= 1'b0;
      unique case (opState_r)
        OP_IDLE:
          if (running && opReq && !opAck_r)
            unique case (opRegion)
              REG_ROM, REG_RAM:
              begin
                memReq_r <= 1'b1;
                memWe_r <= opWe;
                memRam_r <= opRegion == REG_RAM;
                memSize_r <= opSize;
                memAddr_r <= {{6{opPhys[25]}}, opPhys};
                memWdata_r <= opWdata;
                opState_r <= OP_MEM;
              end
              REG_PER:
              begin
                perPend_r <= 1'b1;
                perBus.we <= opWe;
                perBus.size <= opSize;
                perBus.addr <= opPhys[11:0];
                perBus.wdata <= opWdata;
                opState_r <= OP_PER;
              end
              REG_PROH:
              begin
                opAck_r <= 1'b1;
                opFault_r <= 1'b1;
                opRdata_r <= 32'h00000000;
              end
            endcase
        OP_MEM:
          if (memAck)
          begin
            memReq_r <= 1'b0;
            opAck_r <= 1'b1;
            opFault_r <= 1'b0;
            opRdata_r <= memRdata;
            opState_r <= OP_IDLE;
          end
        OP_PER:
          if (perBus.done)
          begin
            opAck_r <= 1'b1;
            opFault_r <= 1'b0;
            opRdata_r <= perBus.rdata;
            opState_r <= OP_IDLE;
          end
        default:
          opState_r <= OP_IDLE;
      endcase
    end

  cpuamd_per_split u_split (
    .clk        (clk),
    .rstN       (rstN),
    .clkEn      (clkEn),
    .up         (perBus.slave),
    .perReq_r   (perReq_r),
    .perWe_r    (perWe_r),
    .perAddr_r  (perAddr_r),
    .perBe_r    (perBe_r),
    .perWdata_r (perWdata_r),
    .perAck     (perAck),
    .perByteReg (perByteReg),
    .perRdata   (perRdata)
  );

endmodule // cpuamd_top

//--- test/cpuamd_monitor.sv
// Assertion checker on the decoder top ports
module cpuamd_monitor
  import cpuamd_pkg::*;
(
  input wire logic         clk,
  input wire logic         rst_n,
  input wire cpuamd_mode_e mode_r,
  input wire logic         modeValid_r,
  input wire logic         bootStart_r,
  input wire logic [31:0]  callTablePtr_r,
  input wire logic         fetchAck_r,
  input wire logic [31:0]  fetchPc_r,
  input wire logic         fetchFault_r,
  input wire logic         prefetchOk_r,
  input wire logic         memReq_r,
  input wire logic         memRam_r,
  input wire logic [31:0]  memAddr_r,
  input wire logic         perReq_r,
  input wire logic [11:0]  perAddr_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ptr_bit_zero: assert property
    (!callTablePtr_r[0])
    else $error("pointer bit 0 set");
  a_ptr_top_zero: assert property
    (callTablePtr_r[31:26] == 6'h00)
    else $error("pointer top bits set");
  a_boot_normal: assert property
    (bootStart_r |-> mode_r == MODE_NORMAL)
    else $error("boot outside normal mode");
  a_fetch_mode: assert property
    (fetchAck_r |-> mode_r == MODE_NORMAL)
    else $error("fetch outside normal mode");
  a_pc_top_zero: assert property
    (fetchAck_r |-> !(|fetchPc_r[31:26]))
    else $error("pc top bits set");
  a_no_per_fetch: assert property
    (fetchAck_r && &fetchPc_r[25:12] |-> fetchFault_r)
    else $error("fetch from peripheral area");
  a_ram_fetch: assert property
    (fetchAck_r && fetchPc_r inside {[RAM_BASE:RAM_END]}
      |-> !fetchFault_r)
    else $error("fetch from ram refused");
  a_no_cross: assert property
    (fetchAck_r && fetchPc_r[25:2] == 24'hFFFBFF |-> !prefetchOk_r)
    else $error("prefetch crosses into peripheral area");
  a_sign_ext: assert property
    (memReq_r |-> memAddr_r[31:26] == {6{memAddr_r[25]}})
    else $error("address not sign extended");
  a_ram_window: assert property
    (memReq_r && memRam_r
      |-> memAddr_r[25:0] inside {[26'h3FFC000:26'h3FFEFFF]})
    else $error("ram access outside window");
  a_mode_held: assert property
    (modeValid_r ##1 modeValid_r |-> $stable(mode_r))
    else $error("mode changed after latch");
  a_half_align: assert property
    (perReq_r |-> !perAddr_r[0])
    else $error("peripheral address odd");
endmodule // cpuamd_monitor

bind cpuamd_top cpuamd_monitor cpuamd_monitor_inst (.clk(clk), .rst_n(rst_n),
  .mode_r(mode_r), .modeValid_r(modeValid_r), .bootStart_r(bootStart_r),
  .callTablePtr_r(callTablePtr_r), .fetchAck_r(fetchAck_r),
  .fetchPc_r(fetchPc_r), .fetchFault_r(fetchFault_r),
  .prefetchOk_r(prefetchOk_r), .memReq_r(memReq_r), .memRam_r(memRam_r),
  .memAddr_r(memAddr_r), .perReq_r(perReq_r), .perAddr_r(perAddr_r));

//--- test/cpuamd_far_model.sv
// Memory and peripheral responder with random latency
module cpuamd_far_model
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        memReq_r,
  input  wire logic        memWe_r,
  input  wire logic [31:0] memAddr_r,
  input  wire logic [31:0] memWdata_r,
  output logic             memAck,
  output logic [31:0]      memRdata,
  input  wire logic        perReq_r,
  input  wire logic        perWe_r,
  input  wire logic [11:0] perAddr_r,
  input  wire logic [1:0]  perBe_r,
  input  wire logic [15:0] perWdata_r,
  output logic             perAck,
  output logic             perByteReg,
  output logic [15:0]      perRdata
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned dly;
  logic [11:0] perLog[$];
  logic [1:0]  lastBe;
  logic [31:0] lastAddr;
  logic [31:0] lastWdata;
  logic [15:0] lastPerWd;

  assign perByteReg = perAddr_r[11];

  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      memAck <= 1'b0;
      perAck <= 1'b0;
      memRdata <= 32'h0F0F0F0F;
      perRdata <= 16'h0F0F;
      dly <= 0;
    end
    else
    begin
      memAck <= 1'b0;
      perAck <= 1'b0;
      memRdata <= ~memRdata;
      perRdata <= ~perRdata;
      if (memReq_r && memAck)
      begin
        lastAddr <= memAddr_r;
        if (memWe_r)
          lastWdata <= memWdata_r;
      end
      if (perReq_r && perAck)
      begin
        perLog.push_back(perAddr_r);
        if (perWe_r)
        begin
          lastBe <= perBe_r;
          lastPerWd <= perWdata_r;
        end
      end
      if ((memReq_r && !memAck) || (perReq_r && !perAck))
      begin
        if (dly != 0)
          dly <= dly - 1;
        else
        begin
          dly <= $urandom_range(3);
          memAck <= memReq_r;
          perAck <= perReq_r;
          memRdata <= memAddr_r ^ 32'h5A5A5A5A;
          perRdata <= {4'hC, perAddr_r};
        end
      end
    end
endmodule // cpuamd_far_model

//--- test/cpuamd_top_tb.sv
// Self-checking bench of the CPU address map decoder
module cpuamd_top_tb
  import cpuamd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1;
  logic flashModePinA = 1'b0, flashModePinB = 1'b0;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, wbAck_r;
  logic [3:0] wbAdr = 4'h0, wbSel = 4'h0;
  logic [31:0] wbDatW = 32'h0, wbDatR_r, callTablePtr_r;
  cpuamd_mode_e mode_r;
  logic modeValid_r, bootStart_r, fetchReq = 1'b0;
  logic [31:0] fetchBase = 32'h0, fetchDisp = 32'h0, fetchPc_r;
  logic fetchAck_r, fetchFault_r, prefetchOk_r, opReq = 1'b0, opWe = 1'b0;
  cpuamd_size_e opSize = SIZE_WORD, memSize_r;
  logic [31:0] opBase = 32'h0, opDisp = 32'h0, opWdata = 32'h0, opRdata_r;
  logic opAck_r, opFault_r, memReq_r, memWe_r, memRam_r, memAck;
  logic [31:0] memAddr_r, memWdata_r, memRdata;
  logic perReq_r, perWe_r, perAck, perByteReg;
  logic [11:0] perAddr_r;
  logic [1:0] perBe_r, romSel = ROM_SEL_RST;
  logic [15:0] perWdata_r, perRdata;
  int miscompares = 0, compares = 0;
  logic [31:0] fTab[9] = '{32'h0, 32'h0000FFFC, 32'h00010000, 32'h0001FFFC,
    32'h00040000, 32'h03FFC000, 32'h03FFEFFC, 32'h03FFF000, 32'h03FFFFFC};
  logic [31:0] dTab[7] = '{32'hFFFF8000, 32'hFFFFC000, 32'h03FFEFFC,
    32'h0003FFFC, 32'h00040000, 32'h000FFFFC, 32'hA7FFC010};

  cpuamd_top cpuamd_top_inst (.*);
  cpuamd_far_model cpuamd_far_model_inst (.clk, .rst_n, .memReq_r,
    .memWe_r, .memAddr_r, .memWdata_r, .memAck, .memRdata, .perReq_r,
    .perWe_r, .perAddr_r, .perBe_r, .perWdata_r, .perAck, .perByteReg,
    .perRdata);

  initial
    forever #2 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic waitHi(ref logic sig);
    int i;
    for (i = 0; i < 40 && sig !== 1'b1; i++)
      @(posedge clk);
    if (sig !== 1'b1)
    begin
      chk(32'h0, 32'h1);
      summarize();
    end
  endtask

  function automatic logic [1:0] region(input logic [25:0] p);
    if (p <= (romSel == 2'h0 ? 26'hFFFF : romSel == 2'h1 ? 26'h1FFFF
        : 26'h3FFFF))
      return 2'h0;
    if (p >= 26'h3FFC000 && p <= 26'h3FFEFFF)
      return 2'h1;
    return p >= 26'h3FFF000 ? 2'h2 : 2'h3;
  endfunction

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatW} <= {2'h3, w, a, 4'hF, d};
    @(posedge clk);
    waitHi(wbAck_r);
    q = wbDatR_r;
    {wbCyc, wbStb} <= 2'h0;
  endtask

  task automatic fetch(input logic [31:0] b, input logic [31:0] d);
    logic [25:0] pc, nx;
    pc = 26'(b + d);
    nx = pc + 26'h4;
    @(posedge clk);
    {fetchReq, fetchBase, fetchDisp} <= {1'b1, b, d};
    @(posedge clk);
    waitHi(fetchAck_r);
    fetchReq <= 1'b0;
    chk(fetchPc_r, {6'h00, pc});
    chk(fetchFault_r, region(pc) > 2'h1);
    chk(prefetchOk_r, !(&nx[25:12]) && !(&pc[25:12]));
  endtask

  task automatic op(input logic w, input cpuamd_size_e s,
                    input logic [31:0] b, input logic [31:0] d);
    @(posedge clk);
    {opReq, opWe, opBase, opDisp} <= {1'b1, w, b, d};
    opSize <= s;
    opWdata <= $urandom();
    @(posedge clk);
    waitHi(opAck_r);
    opReq <= 1'b0;
  endtask

  task automatic dataOp(input logic w, input logic [31:0] b,
                        input logic [31:0] d);
    logic [31:0] a, e;
    a = b + d;
    e = {{6{a[25]}}, a[25:0]};
    op(w, SIZE_WORD, b, d);
    chk(opFault_r, region(a[25:0]) == 2'h3);
    if (region(a[25:0]) < 2'h2)
    begin
      chk(cpuamd_far_model_inst.lastAddr, e);
      if (w)
        chk(cpuamd_far_model_inst.lastWdata, opWdata);
      if (!w)
        chk(opRdata_r, e ^ 32'h5A5A5A5A);
    end
  endtask

  task automatic doReset(input logic a, input logic b, input cpuamd_mode_e m);
    logic boot;
    boot = 1'b0;
    @(posedge clk);
    {rst_n, flashModePinA, flashModePinB} <= {1'b0, a, b};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 10 && modeValid_r !== 1'b1; i++)
    begin
      @(posedge clk);
      boot = boot | (bootStart_r === 1'b1);
    end
    chk(mode_r, m);
    chk(boot, m == MODE_NORMAL);
    chk(fetchPc_r, {6'h00, RESET_ENTRY});
    $display("reset to mode %0d done", m);
  endtask

  initial
  begin
    logic [31:0] q, v;
    void'($urandom(32'h4300));
    doReset(1'b0, 1'b1, MODE_NORMAL);
    wb(1'b0, OFS_CALL_TABLE, 32'h0, q);
    chk(q, {6'h00, CALL_TABLE_RST, 1'b0});
    for (int i = 0; i < 4; i++)
    begin
      v = i == 0 ? 32'hFFFFFFFF : $urandom();
      wb(1'b1, OFS_CALL_TABLE, v, q);
      wb(1'b0, OFS_CALL_TABLE, 32'h0, q);
      chk(q, v & 32'h03FFFFFE);
      chk(callTablePtr_r, v & 32'h03FFFFFE);
    end
    wb(1'b0, 4'hC, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b0, OFS_STATUS, 32'h0, q);
    chk(q[2:0], 3'h4);
    $display("register test done");
    for (int s = 0; s < 3; s++)
    begin
      romSel = 2'(s);
      wb(1'b1, OFS_CONTROL, {30'h0, romSel}, q);
      foreach (fTab[j])
        fetch(fTab[j], 32'h0);
      foreach (dTab[j])
        dataOp(1'(j), dTab[j] - 32'h40, 32'h40);
    end
    wb(1'b1, OFS_CONTROL, 32'h3, q);
    wb(1'b0, OFS_CONTROL, 32'h0, q);
    chk(q[1:0], romSel);
    fetch(32'h03FFFFFC, 32'h8);
    fetch(32'h0, 32'hFFFFFFF8);
    repeat (20)
    begin
      fetch($urandom(), $urandom());
      dataOp(1'($urandom_range(1)), $urandom(), $urandom());
    end
    wb(1'b0, OFS_STATUS, 32'h0, q);
    chk(q[STS_FAULT], 1'b1);
    wb(1'b1, OFS_STATUS, 32'h100, q);
    wb(1'b0, OFS_STATUS, 32'h0, q);
    chk(q[STS_FAULT], 1'b0);
    $display("fetch and data test done");
    cpuamd_far_model_inst.perLog.delete();
    op(1'b0, SIZE_WORD, 32'hFFFFF000, 32'h106);
    chk(opRdata_r, 32'hC106C104);
    chk(cpuamd_far_model_inst.perLog[0], 12'h104);
    chk(cpuamd_far_model_inst.perLog[1], 12'h106);
    op(1'b1, SIZE_HALF, 32'h03FFF8A4, 32'h0);
    chk(cpuamd_far_model_inst.lastBe, 2'h1);
    chk(cpuamd_far_model_inst.lastPerWd[7:0], opWdata[7:0]);
    op(1'b0, SIZE_HALF, 32'h03FFF8A4, 32'h0);
    chk(opRdata_r[7:0], 8'hA4);
    op(1'b0, SIZE_HALF, 32'h03FFF0A6, 32'h0);
    chk(opRdata_r, 32'h0000C0A6);
    op(1'b1, SIZE_BYTE, 32'h03FFF0A5, 32'h0);
    chk(cpuamd_far_model_inst.lastBe, 2'h2);
    $display("peripheral test done");
    clkEn <= 1'b0;
    fetchReq <= 1'b1;
    repeat (4) @(posedge clk);
    chk(fetchAck_r, 1'b0);
    clkEn <= 1'b1;
    waitHi(fetchAck_r);
    fetchReq <= 1'b0;
    $display("clock enable test done");
    flashModePinA <= 1'b1;
    repeat (4) @(posedge clk);
    chk(mode_r, MODE_NORMAL);
    doReset(1'b1, 1'b0, MODE_FLASH_PROG);
    @(posedge clk);
    fetchReq <= 1'b1;
    q = 32'h0;
    repeat (8)
    begin
      @(posedge clk);
      q[0] = q[0] | fetchAck_r;
    end
    fetchReq <= 1'b0;
    chk(q, 32'h0);
    doReset(1'b1, 1'b1, MODE_PROHIBITED);
    summarize();
  end
endmodule // cpuamd_top_tb
